/* verilog/cpdc_defs.svh */
// Timing counts and reset values for the power-down controller.
// Assumes inclusion by the controller only.
`ifndef CPDC_DEFS_SVH
`define CPDC_DEFS_SVH
`define CPDC_SYNC_STAGES 2
`define CPDC_RST_ACTIVE  1'b0
`define CPDC_IRQ_EN_RST  1'b1
`endif

/* verilog/cpdc_pkg.sv */
// Types shared by the power-down controller files.
// Assumes nothing of its surroundings.
`default_nettype none
package cpdc_pkg;
    // Power-down cause states
    typedef enum logic [1:0] {
        CPDC_RUN,
        CPDC_HALT_DOWN,
        CPDC_HOLD_DOWN
    } cpdc_state_t;
endpackage
`default_nettype wire

/* verilog/cpdc_sync.sv */
// Two-flop synchroniser for a vector of pin inputs.
// Assumes asynchronous pins and one clock.
`default_nettype none
module cpdc_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_sync
);
    // Both stages held in one struct
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } cpdc_sync_st_t;
    cpdc_sync_st_t st_r;  // Registered stages
    cpdc_sync_st_t st_nxt;  // Next stages

    // Shift pins through the two stages
    always_comb begin
        st_nxt.meta = pin_in;
        st_nxt.sync = st_r.meta;
    end

    // Register stages, clearing on reset
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_sync = st_r.sync;
endmodule
`default_nettype wire

/* verilog/cpdc_ctrl.sv */
// Power-down mode controller for an 8-bit processor core.
// Assumes pins arrive asynchronously; halt_exec is a core pulse on clk.
`include "cpdc_defs.svh"
`default_nettype none
module cpdc_ctrl (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 halt_exec,
    input  wire logic                 hold_request,
    input  wire logic                 nmi_irq,
    input  wire logic                 vectored_irq_high,
    input  wire logic                 vectored_irq_mid,
    input  wire logic                 vectored_irq_low,
    input  wire logic                 general_irq_request,
    output var  logic                 power_down,
    output var  logic                 bus_hold,
    output var  logic                 hold_ack,
    output var  logic                 irq_service_en,
    output var  logic                 wake_pulse,
    output var  cpdc_pkg::cpdc_state_t pd_state
);
    import cpdc_pkg::*;

    // Whole state of the controller
    typedef struct packed {
        cpdc_state_t state;
        logic        power_down;
        logic        bus_hold;
        logic        hold_ack;
        logic        irq_en;
        logic        wake;
    } cpdc_st_t;
    cpdc_st_t   st_r;  // Registered state
    cpdc_st_t   st_nxt;  // Next state
    logic [5:0] pins_s;  // Synchronised pins
    logic       hold_s;  // Synchronised hold request
    logic       irq_any;  // Any wake-capable interrupt

    // Bring pins into the clock domain
    cpdc_sync #(
        .WIDTH (6)
    ) u_sync (
        .clk      (clk),
        .srst     (srst),
        .pin_in   ({hold_request, nmi_irq, vectored_irq_high, vectored_irq_mid,
                    vectored_irq_low, general_irq_request}),
        .pin_sync (pins_s)
    );

    // Wake-capable interrupt set
    function automatic logic irq_wake(input logic [4:0] p);
        irq_wake = |p;
    endfunction

    assign hold_s  = pins_s[5];
    assign irq_any = irq_wake(pins_s[4:0]);

    // Latency seen from the pins and the core:
    //   halt_exec is sampled directly, so the halt entry shows one
    //   cycle after the pulse.
    //   A pin change needs the two synchroniser stages, so an exit or a
    //   hold entry shows on the third edge after the pin moves.
    // Priority when both causes meet in run:
    //   the halt pulse wins, since the core has already stopped fetching.
    //   If hold is still up after a halt wake, hold power-down follows on
    //   the next edge, after a single run cycle that carries the wake pulse.
    // Hazard: interrupts are levels, so a source left high while running
    //   is ignored but would wake a later halt at once.
    // Wake pulse marks every exit except reset; reset is silent so that
    //   nothing downstream counts a reset as a wake.

    // Next-state logic
    always_comb begin
        st_nxt      = st_r;
        st_nxt.wake = 1'b0;
        unique case (st_r.state)
            CPDC_RUN: begin
                if (halt_exec) begin
                    st_nxt.state = CPDC_HALT_DOWN;
                end else if (hold_s) begin
                    st_nxt.state = CPDC_HOLD_DOWN;
                end
            end
            CPDC_HALT_DOWN: begin
                // Hold pin has no effect here
                if (irq_any) begin
                    st_nxt.state = CPDC_RUN;
                    st_nxt.wake  = 1'b1;
                end
            end
            CPDC_HOLD_DOWN: begin
                // Interrupts ignored; master drops hold to leave
                if (!hold_s) begin
                    st_nxt.state = CPDC_RUN;
                    st_nxt.wake  = 1'b1;
                end
            end
        endcase
        st_nxt.power_down = (st_nxt.state != CPDC_RUN);
        st_nxt.bus_hold   = (st_nxt.state != CPDC_RUN);
        st_nxt.hold_ack   = (st_nxt.state == CPDC_HOLD_DOWN);
        st_nxt.irq_en     = (st_nxt.state != CPDC_HOLD_DOWN);
    end

    // State register; reset leaves either power-down
    always_ff @(posedge clk) begin
        if (srst) begin
            // Reset leaves either power-down without a wake pulse
            st_r        <= '0;
            st_r.state  <= CPDC_RUN;
            st_r.irq_en <= `CPDC_IRQ_EN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign power_down     = st_r.power_down;
    assign bus_hold       = st_r.bus_hold;
    assign hold_ack       = st_r.hold_ack;
    assign irq_service_en = st_r.irq_en;
    assign wake_pulse     = st_r.wake;
    assign pd_state       = st_r.state;

    // Halt enters power-down next cycle
    a_halt_entry: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_RUN && halt_exec) |=> (power_down && bus_hold))
        else $error("halt did not enter power-down");

    // Halt power-down survives hold changes without interrupts
    a_halt_hold_ignored: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_HALT_DOWN && !irq_any) |=> (pd_state == CPDC_HALT_DOWN))
        else $error("halt power-down left without interrupt");

    // Hold request from run enters hold power-down
    a_hold_entry: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_RUN && !halt_exec && hold_s) |=> (pd_state == CPDC_HOLD_DOWN))
        else $error("hold did not enter power-down");

    // Interrupt releases halt power-down with a wake pulse
    a_halt_release: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_HALT_DOWN && irq_any) |=> (!power_down && wake_pulse))
        else $error("interrupt did not release halt");

    // Hold power-down ends only on hold release
    a_hold_release: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_HOLD_DOWN) |=> (power_down == $past(hold_s)))
        else $error("hold power-down exit wrong");

    // Interrupt service off throughout hold power-down
    a_hold_no_irq: assert property (@(posedge clk) disable iff (srst)
        hold_ack |-> !irq_service_en)
        else $error("interrupt service enabled in hold");

    // Each wake source alone releases halt
    a_wake_sources: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_HALT_DOWN && $onehot(pins_s[4:0])) |=> !power_down)
        else $error("single wake source ignored");

    // Dropped hold leaves hold power-down in one cycle
    a_hold_drop: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_HOLD_DOWN && !hold_s) |=> (pd_state == CPDC_RUN) ##1 !wake_pulse)
        else $error("hold drop not honoured");

    // Sync reset returns to run with service enabled
    a_reset_state: assert property (@(posedge clk)
        srst |=> (pd_state == CPDC_RUN && !power_down && irq_service_en && !wake_pulse))
        else $error("reset did not return to run");

    // Bus hold follows power-down in both causes
    a_bus_hold_pd: assert property (@(posedge clk) disable iff (srst)
        bus_hold == power_down)
        else $error("bus hold differs from power-down");

    // Hold acknowledge only in hold power-down
    a_hold_ack_state: assert property (@(posedge clk) disable iff (srst)
        hold_ack == (pd_state == CPDC_HOLD_DOWN))
        else $error("hold acknowledge in wrong state");

    // Interrupts do not end hold power-down
    a_hold_irq_ignored: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_HOLD_DOWN && hold_s) |=> (pd_state == CPDC_HOLD_DOWN))
        else $error("hold power-down left while hold high");

    // Halt wins over hold in the same run cycle
    a_halt_priority: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_RUN && halt_exec && hold_s) |=> (pd_state == CPDC_HALT_DOWN))
        else $error("halt lost to hold");

    // Wake pulse lasts one cycle
    a_wake_one_cycle: assert property (@(posedge clk) disable iff (srst)
        wake_pulse |=> !wake_pulse)
        else $error("wake pulse too long");

    // Idle run stays in run with no wake
    a_run_idle: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_RUN && !halt_exec && !hold_s) |=> (pd_state == CPDC_RUN && !wake_pulse))
        else $error("run left without cause");

    // Halt power-down keeps interrupt service on
    a_halt_irq_en: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_HALT_DOWN) |-> irq_service_en)
        else $error("interrupt service off in halt");

    // Halt holds the bus without a hold acknowledge
    a_halt_no_ack: assert property (@(posedge clk) disable iff (srst)
        (pd_state == CPDC_HALT_DOWN) |-> (!hold_ack && bus_hold))
        else $error("halt bus hold wrong");

    // A wake rises only out of power-down
    a_wake_after_down: assert property (@(posedge clk) disable iff (srst)
        $rose(wake_pulse) |-> $past(power_down))
        else $error("wake without power-down");

    // A wake coincides with run
    a_wake_in_run: assert property (@(posedge clk) disable iff (srst)
        wake_pulse |-> (!power_down && pd_state == CPDC_RUN))
        else $error("wake outside run");
endmodule
`default_nettype wire

/* verif/cpdc_master_model.sv */
// Model of the external bus master and the interrupt sources.
// Assumes the bench commands it at rising clk edges.
`default_nettype none
module cpdc_master_model (
    input  wire logic       clk,
    input  wire logic       want_hold,
    input  wire logic [4:0] want_irq,
    output var  logic       hold_request,
    output var  logic [4:0] irq_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // Master ends its own power-down only by dropping hold; pins settle
    // on the first edge, well inside the bench's reset
    always @(posedge clk) begin
        hold_request <= want_hold;
        irq_pins <= want_irq;
    end
endmodule
`default_nettype wire

/* verif/test_cpu_power_down_control.sv */
// Self-checking bench for the power-down controller.
// Assumes the master model drives all pins; halt_exec comes from here.
`default_nettype none
module test_cpu_power_down_control;
    import cpdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, srst, halt_exec, want_hold, hold_request;
    logic        power_down, bus_hold, hold_ack, irq_service_en, wake_pulse;
    logic [4:0]  want_irq, irq_pins;
    cpdc_state_t pd_state;
    logic [5:0]  stat;
    int          fails, cmp_count, seed, k;
    assign stat = {pd_state, power_down, bus_hold, hold_ack, irq_service_en};
    cpdc_master_model master (.clk(clk), .want_hold(want_hold), .want_irq(want_irq),
        .hold_request(hold_request), .irq_pins(irq_pins));
    cpdc_ctrl uut (.clk(clk), .srst(srst), .halt_exec(halt_exec),
        .hold_request(hold_request), .nmi_irq(irq_pins[0]),
        .vectored_irq_high(irq_pins[1]), .vectored_irq_mid(irq_pins[2]),
        .vectored_irq_low(irq_pins[3]), .general_irq_request(irq_pins[4]),
        .power_down(power_down), .bus_hold(bus_hold), .hold_ack(hold_ack),
        .irq_service_en(irq_service_en), .wake_pulse(wake_pulse), .pd_state(pd_state));
    // Expected outputs: 0 running, 1 halt-entered, 2 hold-entered
    function automatic logic [5:0] expect_of(input int m);
        return (m == 0) ? 6'h01 : ((m == 1) ? 6'h1d : 6'h2e);
    endfunction
    // Compare and count
    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Move to a rising edge, where stimulus changes
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Move to a falling edge, where outputs are settled
    task automatic look();
        @(negedge clk);
    endtask
    // Bounded wait for power_down to reach a level, ends on a falling edge
    task automatic settle(input logic val);
        @(negedge clk);
        for (int n = 0; n < 12 && power_down !== val; n++) @(negedge clk);
    endtask
    // Pulse reset for one edge, then look at the outcome
    task automatic pulse_reset();
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial begin
        seed = 25031;
        fails = 0;
        cmp_count = 0;
        srst = 1'b1;
        halt_exec = 1'b0;
        want_hold = 1'b0;
        want_irq = 5'h00;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        // Each wake source in turn, then a hold episode with noise on interrupts
        for (k = 0; k < 5; k++) begin
            tick(4);
            halt_exec <= 1'b1;
            tick(1);
            halt_exec <= 1'b0;
            settle(1'b1);
            check(stat, expect_of(1));
            tick(1);
            want_hold <= 1'b1;
            tick(6);
            want_hold <= 1'b0;
            tick(6);
            look();
            check(stat, expect_of(1));
            tick(1);
            want_irq <= 5'h01 << k;
            settle(1'b0);
            check({wake_pulse, stat[4:0]}, 6'h21);
            tick(1);
            want_irq <= 5'h00;
            tick(4);
            want_hold <= 1'b1;
            settle(1'b1);
            check(stat, expect_of(2));
            tick(1);
            halt_exec <= 1'b1;
            want_irq <= 5'($random(seed)) | 5'h01;
            tick(1);
            halt_exec <= 1'b0;
            tick(8);
            look();
            check(stat, expect_of(2));
            tick(1);
            want_hold <= 1'b0;
            settle(1'b0);
            check({wake_pulse, stat[4:0]}, 6'h21);
            tick(1);
            want_irq <= 5'h00;
        end
        // Halt and hold meet in one run cycle: halt wins, hold follows the wake
        tick(4);
        want_hold <= 1'b1;
        tick(3);
        halt_exec <= 1'b1;
        tick(1);
        halt_exec <= 1'b0;
        settle(1'b1);
        check(stat, expect_of(1));
        tick(1);
        want_irq <= 5'h10;
        settle(1'b0);
        check({wake_pulse, stat[4:0]}, 6'h21);
        look();
        check(stat, expect_of(2));
        tick(1);
        want_irq <= 5'h00;
        want_hold <= 1'b0;
        settle(1'b0);
        check({wake_pulse, stat[4:0]}, 6'h21);
        // Reset ends both kinds of power-down
        tick(4);
        halt_exec <= 1'b1;
        tick(1);
        halt_exec <= 1'b0;
        settle(1'b1);
        pulse_reset();
        check({wake_pulse, stat[4:0]}, expect_of(0));
        tick(1);
        want_hold <= 1'b1;
        settle(1'b1);
        pulse_reset();
        check({wake_pulse, stat[4:0]}, expect_of(0));
        tick(1);
        want_hold <= 1'b0;
        tick(4);
        give_verdict();
    end
endmodule
`default_nettype wire
